/* src/avs_cfg.svh */
`ifndef AVS_CFG_SVH
`define AVS_CFG_SVH
`define AVS_CODE_HIGH 16'h7FFF
`define AVS_CODE_LOW 16'h8000
`define AVS_ZERO 16'h0000
`define AVS_EXT_BITS 3
`endif

/* src/avs_pkg.sv */
package avs_pkg;
  // per-channel input sample from the converter
  typedef struct packed {
    logic valid;
    logic overflow;
    logic underflow;
    logic [12:0] value;
  } avs_sample_t;
  // output channel configuration
  typedef struct packed {
    logic hold_last;
    logic [15:0] subst;
  } avs_ocfg_t;
endpackage

/* src/avs_core.sv */
`timescale 1ns/10ps
`include "avs_cfg.svh"
module avs_core
  import avs_pkg::*;
#(
  parameter int NUM_IN = 4,
  parameter int NUM_OUT = 4,
  parameter logic signed [15:0] OUT_MAX = 16'sh7EFF,
  parameter logic signed [15:0] OUT_MIN = -16'sh7F00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_ok_pin,
  input wire logic params_new,
  input wire logic params_done,
  input wire logic master_run,
  input wire logic exchange_active,
  input wire logic out_write,
  input wire avs_sample_t [NUM_IN-1:0] sample,
  input wire logic [NUM_IN-1:0] hart_mode,
  input wire avs_ocfg_t [NUM_OUT-1:0] ocfg,
  input wire logic [NUM_OUT-1:0][15:0] out_value,
  output logic [NUM_IN-1:0][15:0] in_word,
  output logic [NUM_OUT-1:0][15:0] dac_word
);

  typedef struct packed {
    logic sup_meta;
    logic sup;
    logic [NUM_IN-1:0] conv_seen;
    logic written;
    logic [NUM_IN-1:0][15:0] in_word;
    logic [NUM_OUT-1:0][15:0] dac_word;
  } avs_state_t;

  avs_state_t st;
  avs_state_t next_st;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic signed [15:0] v;
    v = '0;
    next_st = st;
    next_st.sup_meta = supply_ok_pin;
    next_st.sup = st.sup_meta;
    for (int i = 0; i < NUM_IN; i++) begin
      if (params_new) begin
        next_st.conv_seen[i] = 1'b0;
      end else if (sample[i].valid) begin
        next_st.conv_seen[i] = 1'b1;
      end
      // hart_mode only affects the analog front end; value path is equal
      // substitute codes take priority over any measured data
      if (!st.sup) begin
        next_st.in_word[i] = `AVS_CODE_HIGH;
      end else if (!next_st.conv_seen[i]) begin
        next_st.in_word[i] = `AVS_CODE_HIGH;
      end else if (sample[i].valid && sample[i].overflow) begin
        next_st.in_word[i] = `AVS_CODE_HIGH;
      end else if (sample[i].valid && sample[i].underflow) begin
        next_st.in_word[i] = `AVS_CODE_LOW;
      end else if (sample[i].valid) begin
        // sign-extend 13-bit sample to 16 bits
        next_st.in_word[i] = {{`AVS_EXT_BITS{sample[i].value[12]}}, sample[i].value};
      end
    end
    // first accepted write arms the output path; new parameters disarm it
    if (params_new) begin
      next_st.written = 1'b0;
    end else if (out_write && master_run && params_done) begin
      next_st.written = 1'b1;
    end
    // output priority: no parameters, no exchange, stop, unwritten, write
    for (int j = 0; j < NUM_OUT; j++) begin
      v = signed'(out_value[j]);
      if (!params_done) begin
        next_st.dac_word[j] = `AVS_ZERO;
      end else if (!exchange_active) begin
        next_st.dac_word[j] = ocfg[j].subst;
      end else if (!master_run) begin
        if (!ocfg[j].hold_last) begin
          next_st.dac_word[j] = ocfg[j].subst;
        end
      end else if (!next_st.written) begin
        next_st.dac_word[j] = `AVS_ZERO;
      end else if (out_write) begin
        if (v > OUT_MAX || v < OUT_MIN) begin
          next_st.dac_word[j] = `AVS_ZERO;
        end else begin
          next_st.dac_word[j] = out_value[j];
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.sup_meta <= 1'b0;
      st.sup <= 1'b0;
      st.conv_seen <= '0;
      st.written <= 1'b0;
      st.in_word <= {NUM_IN{`AVS_CODE_HIGH}};
      st.dac_word <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_word = st.in_word;
  assign dac_word = st.dac_word;

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_NOSUP_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    !st.sup |=> st.in_word[0] == `AVS_CODE_HIGH)
    else $error("input not 7FFF without supply");
  AST_NEWPAR_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    params_new |=> st.in_word[0] == `AVS_CODE_HIGH)
    else $error("input not 7FFF after new parameters");
  AST_OVF: assert property (@(posedge clk) disable iff (!rst_n)
    st.sup && st.conv_seen[0] && !params_new && sample[0].valid && sample[0].overflow
    |=> st.in_word[0] == `AVS_CODE_HIGH)
    else $error("overflow not 7FFF");
  AST_UNF: assert property (@(posedge clk) disable iff (!rst_n)
    st.sup && !params_new && sample[0].valid && !sample[0].overflow && sample[0].underflow
    |=> st.in_word[0] == `AVS_CODE_LOW)
    else $error("underflow not 8000");
  AST_NOPAR_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    !params_done |=> st.dac_word[0] == `AVS_ZERO)
    else $error("output not zero before parameters");
  AST_STOP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    params_done && exchange_active && !master_run && ocfg[0].hold_last
    |=> $stable(st.dac_word[0]))
    else $error("output not held in stop");
  AST_NOEX_SUBST: assert property (@(posedge clk) disable iff (!rst_n)
    params_done && !exchange_active |=> st.dac_word[0] == $past(ocfg[0].subst))
    else $error("substitute not driven before exchange");
  AST_RANGE_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    params_done && exchange_active && master_run && st.written && out_write
    && signed'(out_value[0]) > OUT_MAX |=> st.dac_word[0] == `AVS_ZERO)
    else $error("out of range output not zero");
  AST_UNWRITTEN_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    params_done && exchange_active && master_run && !st.written && !out_write
    && !params_new |=> st.dac_word[0] == `AVS_ZERO)
    else $error("output not zero before first write");
  CV_STOP: cover property (@(posedge clk) disable iff (!rst_n)
    master_run ##1 !master_run);
  CV_FIRST_CONV: cover property (@(posedge clk) disable iff (!rst_n)
    !st.conv_seen[0] ##1 st.conv_seen[0]);
  CV_WRITE: cover property (@(posedge clk) disable iff (!rst_n)
    !st.written ##1 st.written);

  // overflow reported on a live channel
  CV_OVF: cover property (@(posedge clk) disable iff (!rst_n)
    st.sup && sample[0].valid && sample[0].overflow);

  // substitute driven before exchange starts
  CV_NOEX: cover property (@(posedge clk) disable iff (!rst_n)
    params_done && !exchange_active);

  ////////////////////////////////////////////////////////////////////////
  // further checks on value paths

  // in-range measurement passes sign-extended
  AST_VALUE_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    st.sup && !params_new && sample[0].valid && !sample[0].overflow && !sample[0].underflow
    |=> st.in_word[0] == {{`AVS_EXT_BITS{$past(sample[0].value[12])}}, $past(sample[0].value)})
    else $error("measured value not passed");

  // missing supply seen through the synchroniser
  AST_SUP_SYNC: assert property (@(posedge clk) disable iff (!rst_n)
    !supply_ok_pin ##1 !supply_ok_pin |-> ##2 st.in_word[0] == `AVS_CODE_HIGH)
    else $error("supply loss not reported");

  // last input channel reads 7FFF without supply, as the first
  AST_LAST_CH: assert property (@(posedge clk) disable iff (!rst_n)
    !st.sup |=> st.in_word[NUM_IN-1] == `AVS_CODE_HIGH)
    else $error("last input channel not 7FFF without supply");

  // underflowing output value drives zero
  AST_LOW_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    params_done && exchange_active && master_run && st.written && out_write
    && signed'(out_value[0]) < OUT_MIN |=> st.dac_word[0] == `AVS_ZERO)
    else $error("underflow output not zero");

  // in-range output value passes unchanged
  AST_OUT_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    params_done && exchange_active && master_run && st.written && out_write && !params_new
    && signed'(out_value[0]) <= OUT_MAX && signed'(out_value[0]) >= OUT_MIN
    |=> st.dac_word[0] == $past(out_value[0]))
    else $error("in range output not passed");

  // stop with substitute reaction
  AST_STOP_SUBST: assert property (@(posedge clk) disable iff (!rst_n)
    params_done && exchange_active && !master_run && !ocfg[0].hold_last
    |=> st.dac_word[0] == $past(ocfg[0].subst))
    else $error("substitute not driven in stop");

  // writes refused before parameters
  AST_WRITE_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
    !params_done && !st.written |=> !st.written)
    else $error("write accepted before parameters");

  // last output channel zero before parameters
  AST_LAST_OUT: assert property (@(posedge clk) disable iff (!rst_n)
    !params_done |=> st.dac_word[NUM_OUT-1] == `AVS_ZERO)
    else $error("last output not zero before parameters");
endmodule

/* tb/avs_master_model.sv */
`timescale 1ns/10ps
// master side: one-cycle output writes on request
module avs_master_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] val,
  output logic out_write,
  output logic [3:0][15:0] out_value
);
  logic pend;
  initial {pend, out_write, out_value} = '0;
  // request taken at the rising edge, clear of the bench's falling-edge drive
  always @(posedge clk) pend <= go;
  // strobe one cycle after request, words scrambled between writes
  always @(negedge clk) begin
    out_write <= pend;
    out_value <= pend ? {4{val}} : ~out_value;
  end
  // unused copy kept out of the way
  always @(negedge clk) begin
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk, rst_n, sup, pn, pd, run, exch, go, hold, sv, so, su, ow;
  logic [12:0] sval;
  logic [15:0] val, subst;
  logic [3:0] hart;
  logic [3:0][15:0] ov, in_word, dac_word;
  logic [3:0][15:0] corner = {16'h80FF, 16'h8100, 16'h7F00, 16'h7EFF};
  int n_mismatch, tests_run, seed;
  avs_core avs_core_i (.clk(clk), .rst_n(rst_n), .supply_ok_pin(sup), .params_new(pn),
    .params_done(pd), .master_run(run), .exchange_active(exch), .out_write(ow),
    .sample({4{sv, so, su, sval}}), .hart_mode(hart), .ocfg({4{hold, subst}}),
    .out_value(ov), .in_word(in_word), .dac_word(dac_word));
  avs_master_model avs_master_model_i (.clk(clk), .go(go), .val(val), .out_write(ow),
    .out_value(ov));
  ////////////////////////////////////////////////////////////////////////////////
  // expected words
  function automatic logic [15:0] in_exp(input logic o, u, input logic [12:0] v);
    return o ? 16'h7FFF : (u ? 16'h8000 : {{3{v[12]}}, v});
  endfunction
  function automatic logic [15:0] dac_exp(input logic [15:0] v);
    return ($signed(v) > 16'sh7EFF || $signed(v) < -16'sh7F00) ? 16'h0000 : v;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] v);
    val = v;
    go = 1;
    @(negedge clk);
    go = 0;
    repeat (2) @(negedge clk);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    complete_run;
  end
  // main sequence, inputs change at falling edge
  initial begin
    {rst_n, pn, pd, run, exch, go, hold, sv, so, su, sval, val, hart} = '0;
    sup = 1;
    seed = 32'h8973;
    subst = 16'($random(seed));
    repeat (4) @(negedge clk);
    rst_n = 1;
    chk("dac", dac_word[0], 16'h0000);
    {pd, run, exch} = 3'b111;
    repeat (5) @(negedge clk);
    chk("in", in_word[1], 16'h7FFF);
    chk("dac", dac_word[2], 16'h0000);
    for (int i = 0; i < 24; i++) begin
      val = (i < 4) ? corner[i] : 16'($random(seed));
      sval = (i == 0) ? 13'h1000 : 13'($random(seed));
      hart = 4'($random(seed));
      {sv, so, su, go} = {1'b1, i % 5 == 3, i % 5 == 4, 1'b1};
      @(negedge clk);
      {sv, go} = 2'b00;
      repeat (2) @(negedge clk);
      chk("in", in_word[i % 4], in_exp(i % 5 == 3, i % 5 == 4, sval));
      chk("dac", dac_word[i % 4], dac_exp(val));
    end
    run = 0;
    repeat (2) @(negedge clk);
    chk("dac", dac_word[3], subst);
    {run, exch} = 2'b10;
    repeat (2) @(negedge clk);
    chk("dac", dac_word[2], subst);
    exch = 1;
    {hold, run} = 2'b11;
    wr(16'h0123);
    run = 0;
    repeat (2) @(negedge clk);
    chk("dac", dac_word[0], 16'h0123);
    sup = 0;
    repeat (4) @(negedge clk);
    chk("in", in_word[2], 16'h7FFF);
    {sup, pn, pd, run} = 4'b1101;
    @(negedge clk);
    pn = 0;
    wr(16'h0042);
    chk("in", in_word[3], 16'h7FFF);
    chk("dac", dac_word[1], 16'h0000);
    {sv, so, su, sval} = {3'b100, 13'h0123};
    @(negedge clk);
    sv = 0;
    @(negedge clk);
    chk("in", in_word[3], 16'h0123);
    complete_run;
  end
endmodule
